// >>> src/tws_pkg.sv
// Package of constants and carrier types for the two-wire status and flag block.
package tws_pkg;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int TWS_ADDR_W = 7;
  localparam int TWS_FIFO_LVL_W = 4;
  localparam int TWS_EXTRA_ADDRS = 3;
  localparam logic [TWS_FIFO_LVL_W-1:0] TWS_LVL_RST = 4'h0;
  localparam logic [1:0] TWS_SYNC_RST = 2'h3;

  // ----------------------------------------
  // Status word field positions
  // ----------------------------------------
  localparam int TWS_ST_W = 14;
  localparam int TWS_ST_TRANSMISSION_COMPLETE_FLAG = 0;
  localparam int TWS_ST_TX_READY_FLAG = 1;
  localparam int TWS_ST_SLAVE_ACCESS_FLAG = 2;
  localparam int TWS_ST_NACK = 3;
  localparam int TWS_ST_ARBLOST = 4;
  localparam int TWS_ST_CLKWAIT = 5;
  localparam int TWS_ST_END_OF_SLAVE_ACCESS_FLAG = 6;
  localparam int TWS_ST_MCODE = 7;
  localparam int TWS_ST_BUS_TIMEOUT_FLAG = 8;
  localparam int TWS_ST_PACKET_CHECK_ERROR_FLAG = 9;
  localparam int TWS_ST_DFLTADR = 10;
  localparam int TWS_ST_HOSTHDR = 11;
  localparam int TWS_ST_LOCK = 12;
  localparam int TWS_ST_SCL = 13;
  localparam logic [TWS_ST_W-1:0] TWS_ST_RST = 14'h0000;

  // ----------------------------------------
  // FIFO status field positions
  // ----------------------------------------
  localparam int TWS_FS_W = 2;
  localparam int TWS_FS_TXTH = 0;
  localparam int TWS_FS_RXTH = 1;
  localparam logic [TWS_FS_W-1:0] TWS_FS_RST = 2'h0;

  // Slave-mode configuration carried together.
  typedef struct packed {
    logic async_wakeup_enable;
    logic data_match_enable;
    logic extra_addr_one_enable;
    logic extra_addr_two_enable;
    logic extra_addr_three_enable;
    logic [TWS_ADDR_W-1:0] own_addr;
    logic [TWS_ADDR_W-1:0] extra_addr_one;
    logic [TWS_ADDR_W-1:0] extra_addr_two;
    logic [TWS_ADDR_W-1:0] extra_addr_three;
  } tws_slave_cfg_t;

  // One-cycle protocol events from the shift engine.
  typedef struct packed {
    logic addr_valid;
    logic [TWS_ADDR_W-1:0] addr;
    logic access_end;
    logic read_nack;
    logic read_ack;
    logic arb_lost;
    logic master_code;
    logic smb_timeout;
    logic pec_error;
    logic default_addr;
    logic host_header;
    logic frame_error;
  } tws_events_t;

endpackage : tws_pkg

// >>> src/tws_sticky_flag.sv
// Sticky event flag that is cleared by a qualified clear, set winning over clear.
`timescale 1ns/100ps
`default_nettype none
module tws_sticky_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  logic flag_reg;
  logic flag_next;

  // A set in the clearing cycle survives for the next read.
  assign flag_next = set | (flag_reg & ~clr);
  assign flag = flag_reg;

  // Flag storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (clk_en) begin
      flag_reg <= flag_next;
    end
  end

endmodule : tws_sticky_flag
`default_nettype wire

// >>> src/tws_status_flags.sv
// Status, FIFO flag and slave address match logic of a two-wire controller.
// What this block does
// - Receive threshold flag sets when rx level rises to meet the threshold.
// - Both FIFO threshold flags can interrupt, masked via enable and disable writes.
// - Reading FIFO status clears all FIFO flags; each flag individually interrupt-maskable.
// - Without async wakeup, match up to three extra enabled slave addresses.
// - Without async wakeup, the data-match enable bit has no effect.
// - Slave access flag asserts when received address equals an enabled address.
// - Slave read: not-acknowledged flag sets on master nack, clears on ack, access end or leaving read mode.
// - Slave write mode acknowledges every received data byte.
// - Master mode arbitration loss sets lost and complete flags; read clears lost.
// - Slave mode stretches clock, flagged, when tx empty in read or rx full in write.
// - End-of-slave-access flag sets when slave access falls; status read clears.
// - Master-code flag sets on master code in slave mode only, held until status read.
// - Bus-timeout flag sets on SMBus timeout, cleared by status read.
// - PEC error flag sets on PEC mismatch, cleared by status read.
// - Default-address flag sets on SMBus default address, cleared by status read.
// - Host-header flag sets on host header address, cleared by status read.
// - Frame errors set and hold lock; only lock-clear command clears it.
// - Status reports the synchronised clock line level, 0 low, 1 high.
`timescale 1ns/100ps
`default_nettype none
module tws_status_flags #(
  parameter int FIFO_LVL_W = tws_pkg::TWS_FIFO_LVL_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic master_mode,
  input wire logic slave_mode,
  input wire logic slave_read_mode,
  input wire tws_pkg::tws_slave_cfg_t slave_cfg,
  input wire tws_pkg::tws_events_t events,
  input wire logic scl_pin,
  input wire logic [FIFO_LVL_W-1:0] rx_fifo_level,
  input wire logic [FIFO_LVL_W-1:0] rx_fifo_threshold_level,
  input wire logic [FIFO_LVL_W-1:0] tx_fifo_level,
  input wire logic [FIFO_LVL_W-1:0] tx_fifo_threshold_level,
  input wire logic tx_holding_empty,
  input wire logic rx_holding_full,
  input wire logic status_read,
  input wire logic fifo_status_read,
  input wire logic lock_clear_command,
  input wire logic [tws_pkg::TWS_FS_W-1:0] fifo_irq_enable_write,
  input wire logic [tws_pkg::TWS_FS_W-1:0] fifo_irq_disable_write,
  output logic [tws_pkg::TWS_ST_W-1:0] status_register,
  output logic [tws_pkg::TWS_FS_W-1:0] fifo_status_register,
  output logic [tws_pkg::TWS_FS_W-1:0] fifo_irq_mask,
  output logic fifo_irq,
  output logic data_ack,
  output logic scl_stretch,
  output logic locked
);
  import tws_pkg::*;

  // ----------------------------------------
  // Clock line synchroniser
  // ----------------------------------------
  logic [1:0] scl_sync_reg;

  // Two stages before the line level is used anywhere.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_sync_reg <= TWS_SYNC_RST;
    end else if (clk_en) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_pin};
    end
  end

  // ----------------------------------------
  // Slave address comparison
  // ----------------------------------------
  logic extra_allowed;
  logic own_hit;
  logic [TWS_EXTRA_ADDRS-1:0] extra_hit;
  logic addr_match;

  assign extra_allowed = ~slave_cfg.async_wakeup_enable;
  assign own_hit = events.addr == slave_cfg.own_addr;
  assign extra_hit[0] = extra_allowed & slave_cfg.extra_addr_one_enable &
                        (events.addr == slave_cfg.extra_addr_one);
  assign extra_hit[1] = extra_allowed & slave_cfg.extra_addr_two_enable &
                        (events.addr == slave_cfg.extra_addr_two);
  assign extra_hit[2] = extra_allowed & slave_cfg.extra_addr_three_enable &
                        (events.addr == slave_cfg.extra_addr_three);
  // data match ignored
  // The data-match bit is deliberately left out of the match term.
  assign addr_match = events.addr_valid & slave_mode & (own_hit | (|extra_hit));

  // ----------------------------------------
  // Slave access tracking
  // ----------------------------------------
  logic slave_access_flag_reg;
  logic slave_access_flag_next;
  logic slave_access_flag_fall;

  assign slave_access_flag_next = addr_match | (slave_access_flag_reg & ~events.access_end);
  assign slave_access_flag_fall = slave_access_flag_reg & ~slave_access_flag_next & slave_mode;

  // Slave access state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slave_access_flag_reg <= 1'b0;
    end else if (clk_en) begin
      slave_access_flag_reg <= slave_access_flag_next;
    end
  end

  // ----------------------------------------
  // Not-acknowledged and transfer flags
  // ----------------------------------------
  logic nack_reg;
  logic transmission_complete_flag_reg;
  logic arb_evt;

  assign arb_evt = events.arb_lost & master_mode;

  // read nack level
  // Nack holds 1 after a refused byte until the next acknowledged one, access end or leaving read mode.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nack_reg <= 1'b0;
    end else if (clk_en) begin
      if (slave_read_mode & slave_access_flag_reg & events.read_nack) begin
        nack_reg <= 1'b1;
      end else if (~slave_read_mode | events.read_ack | slave_access_flag_fall) begin
        nack_reg <= 1'b0;
      end
    end
  end

  // complete with loss
  // Transfer complete rises with a lost arbitration and falls on a new access.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transmission_complete_flag_reg <= 1'b1;
    end else if (clk_en) begin
      if (arb_evt | slave_access_flag_fall) begin
        transmission_complete_flag_reg <= 1'b1;
      end else if (addr_match) begin
        transmission_complete_flag_reg <= 1'b0;
      end
    end
  end

  assign data_ack = slave_mode & slave_access_flag_reg & ~slave_read_mode;

  assign scl_stretch = slave_mode & slave_access_flag_reg &
                       ((slave_read_mode & tx_holding_empty) |
                        (~slave_read_mode & rx_holding_full));

  // ----------------------------------------
  // Cleared-on-read status flags
  // ----------------------------------------
  localparam int NCOR = 7;
  logic [NCOR-1:0] cor_set;
  logic [NCOR-1:0] cor_flag;

  assign cor_set[0] = arb_evt;
  assign cor_set[1] = slave_access_flag_fall;
  assign cor_set[2] = events.master_code & slave_mode;
  assign cor_set[3] = events.smb_timeout;
  assign cor_set[4] = events.pec_error;
  assign cor_set[5] = events.default_addr;
  assign cor_set[6] = events.host_header;

  for (genvar i = 0; i < NCOR; i++) begin : g_cor
    tws_sticky_flag u_flag (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .set(cor_set[i]),
      .clr(status_read),
      .flag(cor_flag[i])
    );
  end

  // ----------------------------------------
  // Lock on frame errors
  // ----------------------------------------
  // lock and clear
  tws_sticky_flag u_lock (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set(events.frame_error),
    .clr(lock_clear_command),
    .flag(locked)
  );

  // ----------------------------------------
  // FIFO threshold flags
  // ----------------------------------------
  logic rx_above_reg;
  logic tx_above_reg;
  logic rx_above;
  logic tx_above;
  logic [TWS_FS_W-1:0] fs_set;
  logic [TWS_FS_W-1:0] fs_flag;
  logic [TWS_FS_W-1:0] fmask_reg;

  assign rx_above = rx_fifo_level >= rx_fifo_threshold_level;
  assign tx_above = tx_fifo_level >= tx_fifo_threshold_level;
  assign fs_set[TWS_FS_RXTH] = rx_above & ~rx_above_reg;
  // The transmit flag fires when the level drops from at or above the threshold to below it.
  assign fs_set[TWS_FS_TXTH] = ~tx_above_reg & 1'b0 | (tx_above_reg & ~tx_above) |
                               ((tx_fifo_level == tx_fifo_threshold_level) &
                                (tx_fifo_level != tws_pkg::TWS_LVL_RST) & 1'b0);

  // Previous-cycle comparison results for edge detection.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_above_reg <= 1'b0;
      tx_above_reg <= 1'b0;
    end else if (clk_en) begin
      rx_above_reg <= rx_above;
      tx_above_reg <= tx_above;
    end
  end

  for (genvar j = 0; j < TWS_FS_W; j++) begin : g_fs
    tws_sticky_flag u_fflag (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .set(fs_set[j]),
      .clr(fifo_status_read),
      .flag(fs_flag[j])
    );
  end

  // enable and disable
  // Enable writes win over disable writes to the same bit.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fmask_reg <= TWS_FS_RST;
    end else if (clk_en) begin
      fmask_reg <= (fmask_reg & ~fifo_irq_disable_write) | fifo_irq_enable_write;
    end
  end

  assign fifo_irq = |(fs_flag & fmask_reg);
  assign fifo_irq_mask = fmask_reg;
  assign fifo_status_register = fs_flag;

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  // sampled clock line
  always_comb begin
    status_register = TWS_ST_RST;
    status_register[TWS_ST_TRANSMISSION_COMPLETE_FLAG] = transmission_complete_flag_reg;
    status_register[TWS_ST_TX_READY_FLAG] = tx_holding_empty & ~nack_reg;
    status_register[TWS_ST_SLAVE_ACCESS_FLAG] = slave_access_flag_reg;
    status_register[TWS_ST_NACK] = nack_reg;
    status_register[TWS_ST_ARBLOST] = cor_flag[0];
    status_register[TWS_ST_CLKWAIT] = scl_stretch;
    status_register[TWS_ST_END_OF_SLAVE_ACCESS_FLAG] = cor_flag[1];
    status_register[TWS_ST_MCODE] = cor_flag[2];
    status_register[TWS_ST_BUS_TIMEOUT_FLAG] = cor_flag[3];
    status_register[TWS_ST_PACKET_CHECK_ERROR_FLAG] = cor_flag[4];
    status_register[TWS_ST_DFLTADR] = cor_flag[5];
    status_register[TWS_ST_HOSTHDR] = cor_flag[6];
    status_register[TWS_ST_LOCK] = locked;
    status_register[TWS_ST_SCL] = scl_sync_reg[1];
  end

endmodule : tws_status_flags
`default_nettype wire

// >>> bench/tws_status_flags_properties.sv
// Concurrent checks on the ports of the two-wire status and flag block.
`timescale 1ns/100ps
`default_nettype none
module tws_status_flags_properties #(
  parameter int FIFO_LVL_W = tws_pkg::TWS_FIFO_LVL_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic master_mode,
  input wire logic slave_mode,
  input wire logic slave_read_mode,
  input wire tws_pkg::tws_slave_cfg_t slave_cfg,
  input wire tws_pkg::tws_events_t events,
  input wire logic scl_pin,
  input wire logic [FIFO_LVL_W-1:0] rx_fifo_level,
  input wire logic [FIFO_LVL_W-1:0] rx_fifo_threshold_level,
  input wire logic status_read,
  input wire logic lock_clear_command,
  input wire logic [tws_pkg::TWS_ST_W-1:0] status_register,
  input wire logic [tws_pkg::TWS_FS_W-1:0] fifo_status_register,
  input wire logic data_ack,
  input wire logic locked
);
  import tws_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Address arrival on the own address, on an enabled extra address, and end of access.
  sequence own_hit_s;
    clk_en && slave_mode && events.addr_valid && events.addr == slave_cfg.own_addr;
  endsequence
  sequence extra_hit_s;
    clk_en && slave_mode && events.addr_valid && !slave_cfg.async_wakeup_enable
      && slave_cfg.extra_addr_two_enable && events.addr == slave_cfg.extra_addr_two;
  endsequence
  sequence access_end_s;
    clk_en && slave_mode && status_register[TWS_ST_SLAVE_ACCESS_FLAG] && events.access_end
      && !events.addr_valid;
  endsequence
  own_match_a: assert property (own_hit_s |=> status_register[TWS_ST_SLAVE_ACCESS_FLAG])
    else $error("slave access missing on own address");
  extra_match_a: assert property (extra_hit_s |=> status_register[TWS_ST_SLAVE_ACCESS_FLAG])
    else $error("slave access missing on extra address");
  access_end_a: assert property (access_end_s |=> !status_register[TWS_ST_SLAVE_ACCESS_FLAG]
    && status_register[TWS_ST_END_OF_SLAVE_ACCESS_FLAG])
    else $error("end of access not flagged");
  nack_set_a: assert property (clk_en && slave_read_mode && events.read_nack
    && status_register[TWS_ST_SLAVE_ACCESS_FLAG]
    |=> status_register[TWS_ST_NACK])
    else $error("nack flag not set");
  write_ack_a: assert property (slave_mode && !slave_read_mode
    && status_register[TWS_ST_SLAVE_ACCESS_FLAG] |-> data_ack)
    else $error("write byte not acknowledged");
  arb_lost_a: assert property (clk_en && master_mode && events.arb_lost
    |=> status_register[TWS_ST_ARBLOST] && status_register[TWS_ST_TRANSMISSION_COMPLETE_FLAG])
    else $error("arbitration loss not flagged");
  bus_timeout_flag_set_a: assert property (clk_en && events.smb_timeout |=> status_register[TWS_ST_BUS_TIMEOUT_FLAG])
    else $error("timeout flag not set");
  read_clear_a: assert property (clk_en && status_read && !events.pec_error
    |=> !status_register[TWS_ST_PACKET_CHECK_ERROR_FLAG])
    else $error("error flag survives status read");
  lock_set_a: assert property (clk_en && events.frame_error |=> locked)
    else $error("lock not set on frame error");
  lock_hold_a: assert property (locked && !(clk_en && lock_clear_command) |=> locked)
    else $error("lock dropped without clear command");
  scl_low_a: assert property (clk_en && !scl_pin ##1 clk_en && !scl_pin
    |=> !status_register[TWS_ST_SCL])
    else $error("clock line level not reported");
  rx_thresh_a: assert property (clk_en && rx_fifo_level < rx_fifo_threshold_level ##1
    clk_en && rx_fifo_level >= rx_fifo_threshold_level |=> ##[0:1]
    fifo_status_register[TWS_FS_RXTH])
    else $error("receive threshold flag not set");
endmodule : tws_status_flags_properties
bind tws_status_flags tws_status_flags_properties #(.FIFO_LVL_W(FIFO_LVL_W)) u_props (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .master_mode(master_mode),
  .slave_mode(slave_mode), .slave_read_mode(slave_read_mode), .slave_cfg(slave_cfg),
  .events(events), .scl_pin(scl_pin), .rx_fifo_level(rx_fifo_level),
  .rx_fifo_threshold_level(rx_fifo_threshold_level), .status_read(status_read),
  .lock_clear_command(lock_clear_command), .status_register(status_register),
  .fifo_status_register(fifo_status_register), .data_ack(data_ack), .locked(locked)
);
`default_nettype wire

// >>> bench/tws_bus_model.sv
// Far-side bus model that drives the serial clock line during frames.
`timescale 1ns/100ps
`default_nettype none
module tws_bus_model #(
  parameter int HALF_NS = 40
) (
  input wire logic frame_on,
  output logic scl_pin
);
  // The line idles high through its pull-up and toggles only inside a frame.
  initial begin
    scl_pin = 1'b1;
    #13;
    forever begin
      wait (frame_on);
      #(HALF_NS);
      scl_pin = frame_on ? ~scl_pin : 1'b1;
    end
  end
endmodule : tws_bus_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking testbench for the two-wire status and flag block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tws_pkg::*;
  localparam logic [6:0] ADRS [5] = '{7'h2A, 7'h11, 7'h22, 7'h33, 7'h55};
  localparam logic [4:0] HITS = 5'h07;
  logic clk, rst_n, clk_en, master_mode, slave_mode, slave_read_mode, frame_on, scl_pin;
  logic status_read, fifo_status_read, lock_clear_command, data_ack, scl_stretch, locked;
  logic tx_holding_empty, rx_holding_full, fifo_irq;
  logic [3:0] rx_lvl, rx_th, tx_lvl, tx_th;
  logic [1:0] fie, fid, fsr, fmask;
  logic [TWS_ST_W-1:0] st;
  tws_slave_cfg_t slave_cfg;
  tws_events_t events;
  int error_cnt, comparisons;
  tws_status_flags tws_status_flags_i (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .master_mode(master_mode),
    .slave_mode(slave_mode), .slave_read_mode(slave_read_mode), .slave_cfg(slave_cfg),
    .events(events), .scl_pin(scl_pin), .rx_fifo_level(rx_lvl),
    .rx_fifo_threshold_level(rx_th), .tx_fifo_level(tx_lvl), .tx_fifo_threshold_level(tx_th),
    .tx_holding_empty(tx_holding_empty), .rx_holding_full(rx_holding_full),
    .status_read(status_read), .fifo_status_read(fifo_status_read),
    .lock_clear_command(lock_clear_command), .fifo_irq_enable_write(fie),
    .fifo_irq_disable_write(fid), .status_register(st), .fifo_status_register(fsr),
    .fifo_irq_mask(fmask), .fifo_irq(fifo_irq), .data_ack(data_ack),
    .scl_stretch(scl_stretch), .locked(locked)
  );
  tws_bus_model tws_bus_model_i (.frame_on(frame_on), .scl_pin(scl_pin));
  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // One-cycle pulse: c is {lock clear, fifo status read, status read}.
  task automatic hit(input tws_events_t e, input logic [2:0] c,
                     input logic [1:0] en = 2'h0, input logic [1:0] dis = 2'h0);
    @(posedge clk);
    events <= e;
    {lock_clear_command, fifo_status_read, status_read} <= c;
    fie <= en;
    fid <= dis;
    @(posedge clk);
    events <= '0;
    {lock_clear_command, fifo_status_read, status_read} <= 3'h0;
    fie <= 2'h0;
    fid <= 2'h0;
    #1;
  endtask : hit
  task automatic t_cor;
    logic [$bits(tws_events_t)-1:0] v;
    for (int k = 1; k <= 5; k++) begin
      v = '0;
      v[k] = 1'b1;
      hit(v, 3'h0);
      chk(st[12-k], 1'b1);
      hit(v, 3'h1);
      chk(st[12-k], 1'b1);
      hit('0, 3'h1);
      chk(st[12-k], 1'b0);
    end
  endtask : t_cor
  task automatic t_addr;
    tws_events_t e;
    for (int i = 0; i < 5; i++) begin
      e = '0;
      e.addr_valid = 1'b1;
      e.addr = ADRS[i];
      hit(e, 3'h0);
      chk({st[TWS_ST_SLAVE_ACCESS_FLAG], data_ack}, {2{HITS[i]}});
      if (HITS[i]) begin
        e = '0;
        e.access_end = 1'b1;
        hit(e, 3'h0);
        chk({st[TWS_ST_SLAVE_ACCESS_FLAG], st[TWS_ST_END_OF_SLAVE_ACCESS_FLAG], st[TWS_ST_TRANSMISSION_COMPLETE_FLAG]}, 3'h3);
        hit('0, 3'h1);
        chk(st[TWS_ST_END_OF_SLAVE_ACCESS_FLAG], 1'b0);
      end
    end
  endtask : t_addr
  task automatic t_nack;
    tws_events_t e;
    @(posedge clk);
    slave_read_mode <= 1'b1;
    e = '0;
    e.addr_valid = 1'b1;
    e.addr = 7'h2A;
    hit(e, 3'h0);
    chk(scl_stretch, 1'b1);
    e = '0;
    e.read_nack = 1'b1;
    hit(e, 3'h0);
    chk(st[TWS_ST_NACK], 1'b1);
    chk(st[TWS_ST_TX_READY_FLAG], 1'b0);
    e = '0;
    e.read_ack = 1'b1;
    hit(e, 3'h0);
    chk(st[TWS_ST_NACK], 1'b0);
    e = '0;
    e.access_end = 1'b1;
    hit(e, 3'h1);
    hit('0, 3'h1);
    @(posedge clk);
    slave_read_mode <= 1'b0;
  endtask : t_nack
  task automatic t_arb;
    tws_events_t e;
    e = '0;
    e.arb_lost = 1'b1;
    e.master_code = 1'b1;
    @(posedge clk);
    slave_mode <= 1'b0;
    master_mode <= 1'b1;
    hit(e, 3'h0);
    chk({st[TWS_ST_ARBLOST], st[TWS_ST_TRANSMISSION_COMPLETE_FLAG], st[TWS_ST_MCODE]}, 3'h6);
    hit('0, 3'h1);
    chk(st[TWS_ST_ARBLOST], 1'b0);
    e = '0;
    e.frame_error = 1'b1;
    hit(e, 3'h0);
    chk({locked, st[TWS_ST_LOCK]}, 2'h3);
    hit('0, 3'h1);
    chk({locked, st[TWS_ST_LOCK]}, 2'h3);
    hit('0, 3'h4);
    chk({locked, st[TWS_ST_LOCK]}, 2'h0);
  endtask : t_arb
  task automatic t_fifo;
    @(posedge clk);
    rx_lvl <= 4'h4;
    tx_lvl <= 4'h1;
    step(3);
    chk({fsr, fifo_irq}, 3'h6);
    hit('0, 3'h0, 2'h3);
    chk({fmask, fifo_irq}, 3'h7);
    hit('0, 3'h0, 2'h0, 2'h2);
    chk({fmask, fifo_irq}, 3'h3);
    hit('0, 3'h2);
    chk(fsr[TWS_FS_RXTH], 1'b0);
  endtask : t_fifo
  task automatic t_scl;
    @(posedge clk);
    frame_on <= 1'b1;
    repeat (2) begin
      @(posedge scl_pin);
      step(4);
      chk(st[TWS_ST_SCL], 1'b1);
      @(negedge scl_pin);
      step(4);
      chk(st[TWS_ST_SCL], 1'b0);
    end
    frame_on <= 1'b0;
    step(40);
    chk(st[TWS_ST_SCL], 1'b1);
  endtask : t_scl
  task automatic finish_test;
    $display("comparisons %0d, error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence: reset, then each scenario in turn.
  initial begin
    {rst_n, master_mode, slave_read_mode, frame_on, status_read, fifo_status_read} = 6'h0;
    {clk_en, slave_mode, tx_holding_empty, rx_holding_full, lock_clear_command} = 5'h1C;
    {rx_lvl, rx_th, tx_lvl, tx_th} = 16'h0444;
    {fie, fid, events} = '0;
    slave_cfg = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 7'h2A, 7'h11, 7'h22, 7'h33};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    chk({st[13:2], st[0]}, 13'h1001);
    t_cor;
    t_addr;
    t_nack;
    t_arb;
    t_fifo;
    t_scl;
    finish_test;
  end
  // Watchdog cuts a hang short.
  initial begin
    #20000;
    error_cnt++;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
